// file: rtl/pfc_switch_mode_control.sv
// PFC switch-mode controller: mode select, on/off timing, valley qualify.
// Assumes ADC samples arrive as same-clock words; demag comparator is async.
`timescale 1ns/1ps
module pfc_switch_mode_control #(
  parameter int ADC_W = pfc_ctrl_pkg::ADC_W,
  parameter int TIME_W = pfc_ctrl_pkg::TIME_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Sense samples
  input wire logic [ADC_W-1:0] output_feedback_current,
  input wire logic [ADC_W-1:0] line_sense_current,
  input wire logic [ADC_W-1:0] output_power_estimate,
  input wire logic half_line_start,
  input wire logic demag_sense,
  // Power stage
  output logic gate_drive_out,
  output logic aux_below_zero_pulse,
  output logic [1:0] mode_out
);
  // Narrower words cannot hold the reference and timing constants
  if (ADC_W < 16 || TIME_W < 16 ||
      pfc_ctrl_pkg::QUALIFY_CYCLES > 255) begin : g_bad_params
    $error("pfc_switch_mode_control: unsupported parameters");
  end

  // Async comparator sync
  logic dm_s1_reg, dm_s2_reg, dm_s3_reg;
  logic [7:0] qual_reg, qual_next;
  logic pulse_reg, pulse_next;
  pfc_ctrl_pkg::mode_type mode_reg, mode_next;
  logic skip_reg, skip_next;
  logic burst_tog_reg, burst_tog_next;
  pfc_ctrl_pkg::sw_state_type st_reg, st_next;
  logic [TIME_W-1:0] cnt_reg, cnt_next;
  logic [TIME_W-1:0] per_reg, per_next;
  logic [TIME_W-1:0] ton_reg, ton_next;
  logic gate_reg, gate_next;

  function automatic logic [ADC_W-1:0] pct(input logic [ADC_W-1:0] v,
                                           input int p);
    logic [ADC_W+7:0] prod;
    prod = (ADC_W+8)'(v) * (ADC_W+8)'(p);
    return ADC_W'(prod / (ADC_W+8)'(100));
  endfunction

  logic [ADC_W-1:0] ifb_lo, ifb_hi, pwr_lo;
  assign ifb_lo = pct(pfc_ctrl_pkg::IREF_CODE,
                      pfc_ctrl_pkg::STARTUP_ENTRY_PCT);
  assign ifb_hi = pct(pfc_ctrl_pkg::IREF_CODE, pfc_ctrl_pkg::STARTUP_EXIT_PCT);
  assign pwr_lo = pct(pfc_ctrl_pkg::POWER_NOMINAL, pfc_ctrl_pkg::BURST_PCT);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dm_s1_reg <= 1'b0;
      dm_s2_reg <= 1'b0;
      dm_s3_reg <= 1'b0;
    end else begin
      dm_s1_reg <= demag_sense;
      dm_s2_reg <= dm_s1_reg;
      dm_s3_reg <= dm_s2_reg;
    end
  end

  // Valley qualify: glitches shorter than the blanking time are dropped
  always_comb begin
    qual_next = qual_reg;
    pulse_next = 1'b0;
    if (!dm_s2_reg) begin
      qual_next = '0;
      pulse_next = dm_s3_reg &&
        (qual_reg >= 8'(pfc_ctrl_pkg::QUALIFY_CYCLES));
    end else if (qual_reg < 8'(pfc_ctrl_pkg::QUALIFY_CYCLES)) begin
      qual_next = qual_reg + 8'h01;
    end
  end

  // Mode select, hysteresis on startup only (burst uses one threshold); burst skip decided only at half-line edges
  always_comb begin
    mode_next = mode_reg;
    skip_next = skip_reg;
    burst_tog_next = burst_tog_reg;
    if (output_feedback_current < ifb_lo) begin
      mode_next = pfc_ctrl_pkg::MODE_STARTUP;
    end else if (mode_reg == pfc_ctrl_pkg::MODE_STARTUP) begin
      if (output_feedback_current >= ifb_hi) begin
        mode_next = pfc_ctrl_pkg::MODE_NORMAL;
      end
    end else if (output_power_estimate < pwr_lo) begin
      mode_next = pfc_ctrl_pkg::MODE_BURST;
    end else begin
      mode_next = pfc_ctrl_pkg::MODE_NORMAL;
    end
    if (half_line_start) begin
      burst_tog_next = !burst_tog_reg;
      skip_next = (mode_reg == pfc_ctrl_pkg::MODE_BURST) &&
                  burst_tog_reg;
    end
  end

  // Switch cycle timing
  logic [TIME_W-1:0] ton_norm;
  always_comb begin
    // Error-driven on-time; small at light load keeps PFC
    ton_norm = ton_reg;
    if (output_feedback_current < pfc_ctrl_pkg::IREF_CODE &&
        ton_reg < pfc_ctrl_pkg::TON_MAX) begin
      ton_norm = ton_reg + TIME_W'(1);
    end else if (output_feedback_current > pfc_ctrl_pkg::IREF_CODE &&
                 ton_reg > pfc_ctrl_pkg::TON_MIN) begin
      ton_norm = ton_reg - TIME_W'(1);
    end
  end

  // Boundary off-time ton*Vin/(Vout-Vin), saturated to the counter width
  // so a near-equal line and output cannot wrap into a short off-time
  localparam int PROD_W = TIME_W + ADC_W;
  logic [PROD_W-1:0] toff_wide;
  logic [TIME_W-1:0] toff_calc;
  always_comb begin
    toff_wide = PROD_W'(ton_reg);
    toff_calc = ton_reg;
    if (output_feedback_current > line_sense_current) begin
      toff_wide = (PROD_W'(ton_reg) * PROD_W'(line_sense_current)) /
                  PROD_W'(output_feedback_current - line_sense_current);
      if (toff_wide > PROD_W'({TIME_W{1'b1}})) begin
        toff_calc = '1;
      end else begin
        toff_calc = TIME_W'(toff_wide);
      end
    end
  end

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    per_next = per_reg;
    ton_next = ton_reg;
    gate_next = 1'b0;
    if (per_reg != '0) begin
      per_next = per_reg - TIME_W'(1);
    end
    case (st_reg)
      pfc_ctrl_pkg::SW_WAIT: begin
        // Later valleys taken when the period floor is not yet met
        if (pulse_reg && per_reg == '0 && !skip_reg) begin
          st_next = pfc_ctrl_pkg::SW_ON;
          per_next = TIME_W'(pfc_ctrl_pkg::MIN_PERIOD_CYCLES);
          if (mode_reg == pfc_ctrl_pkg::MODE_STARTUP) begin
            ton_next = pfc_ctrl_pkg::STARTUP_TON;
          end else begin
            ton_next = ton_norm;
          end
          cnt_next = (mode_reg == pfc_ctrl_pkg::MODE_STARTUP) ?
                     pfc_ctrl_pkg::STARTUP_TON : ton_norm;
          gate_next = 1'b1;
        end
      end
      pfc_ctrl_pkg::SW_ON: begin
        gate_next = 1'b1;
        if (cnt_reg <= TIME_W'(1)) begin
          gate_next = 1'b0;
          st_next = pfc_ctrl_pkg::SW_OFF;
          // At low line the boundary off-time nears the demag time, so the
          // valley arrives early and the stage runs quasi-critical
          cnt_next = toff_calc;
        end else begin
          cnt_next = cnt_reg - TIME_W'(1);
        end
      end
      pfc_ctrl_pkg::SW_OFF: begin
        if (cnt_reg == '0) begin
          st_next = pfc_ctrl_pkg::SW_WAIT;
        end else begin
          cnt_next = cnt_reg - TIME_W'(1);
        end
      end
      default: st_next = pfc_ctrl_pkg::SW_WAIT;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      qual_reg <= '0;
      pulse_reg <= 1'b0;
      mode_reg <= pfc_ctrl_pkg::MODE_STARTUP;
      skip_reg <= 1'b0;
      burst_tog_reg <= 1'b0;
      st_reg <= pfc_ctrl_pkg::SW_WAIT;
      cnt_reg <= '0;
      per_reg <= '0;
      ton_reg <= pfc_ctrl_pkg::TON_RESET;
      gate_reg <= 1'b0;
    end else begin
      qual_reg <= qual_next;
      pulse_reg <= pulse_next;
      mode_reg <= mode_next;
      skip_reg <= skip_next;
      burst_tog_reg <= burst_tog_next;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      per_reg <= per_next;
      ton_reg <= ton_next;
      gate_reg <= gate_next;
    end
  end

  assign gate_drive_out = gate_reg;
  assign aux_below_zero_pulse = pulse_reg;
  assign mode_out = mode_reg;
endmodule

// file: shared/pfc_ctrl_pkg.sv
// Constants for the boost power-factor switch-mode controller.
// Assumes a 100 MHz core clock and current codes of 2 nA per step.
package pfc_ctrl_pkg;
  localparam int CLK_MHZ = 100;
  localparam int QUALIFY_NS = 200;
  localparam int QUALIFY_CYCLES = (QUALIFY_NS * CLK_MHZ + 999) / 1000;
  localparam int FSW_MAX_KHZ = 70;
  localparam int MIN_PERIOD_CYCLES = (CLK_MHZ * 1000 + FSW_MAX_KHZ - 1)
                                     / FSW_MAX_KHZ;
  localparam int ADC_W = 16;
  localparam int TIME_W = 16;
  // Feedback reference of 129 uA; a 2 nA step keeps it inside 16 bits
  localparam int IREF_NA = 129000;
  localparam int CODE_STEP_NA = 2;
  localparam logic [ADC_W-1:0] IREF_CODE = ADC_W'(IREF_NA / CODE_STEP_NA);
  localparam int STARTUP_ENTRY_PCT = 90;
  localparam int STARTUP_EXIT_PCT = 100;
  localparam int BURST_PCT = 5;
  localparam logic [ADC_W-1:0] POWER_NOMINAL = 16'hFFFF;
  localparam logic [TIME_W-1:0] STARTUP_TON = 16'h0190;
  localparam logic [TIME_W-1:0] TON_MIN = 16'h0010;
  localparam logic [TIME_W-1:0] TON_MAX = 16'h0400;
  localparam logic [TIME_W-1:0] TON_RESET = 16'h0100;
  localparam logic [TIME_W-1:0] GAIN_SHIFT = 16'h0004;
  typedef enum logic [1:0] {MODE_STARTUP, MODE_NORMAL, MODE_BURST} mode_type;
  typedef enum logic [1:0] {SW_WAIT, SW_ON, SW_OFF} sw_state_type;
endpackage

// file: testbench/boost_stage_model.sv
// Boost stage stand-in: aux winding ringing seen by the comparator.
// Assumes gate active high; the bench sets the ring high time.
`timescale 1ns/1ps
module boost_stage_model (
  // Clock and gate
  input wire logic core_clk,
  input wire logic gate_drive_out,
  // Ringing shape
  input wire logic [7:0] ring_high,
  // Comparator
  output logic demag_sense
);
  logic [7:0] ph_reg = '0;
  // Comparator held low while the switch conducts
  always_ff @(posedge core_clk) begin
    if (gate_drive_out || ph_reg >= ring_high + 8'h0A) ph_reg <= '0;
    else ph_reg <= ph_reg + 8'h01;
  end
  assign demag_sense = !gate_drive_out && ph_reg < ring_high;
endmodule

// file: testbench/pfc_ctrl_props.sv
// Port-level checks on the PFC switch-mode controller.
// Assumes one core clock and the mode encoding of the package.
`timescale 1ns/1ps
module pfc_ctrl_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Watched ports
  input wire logic [15:0] output_feedback_current,
  input wire logic [15:0] output_power_estimate,
  input wire logic demag_sense,
  input wire logic gate_drive_out,
  input wire logic aux_below_zero_pulse,
  input wire logic [1:0] mode_out
);
  logic [15:0] hi_reg, run_reg, gap_reg, on_reg;
  logic gate_d_reg;
  logic [1:0] pulse_mode_reg;
  // Saturating gap keeps the first gate rise after reset legal
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hi_reg <= '0;
      run_reg <= '0;
      gap_reg <= 16'hFFFF;
      on_reg <= '0;
      gate_d_reg <= 1'b0;
      pulse_mode_reg <= 2'h0;
    end else begin
      hi_reg <= demag_sense ? hi_reg + 16'h0001 : 16'h0000;
      if (!demag_sense && hi_reg != '0) run_reg <= hi_reg;
      gate_d_reg <= gate_drive_out;
      // Mode seen with the valley that starts a cycle sets its on-time
      if (aux_below_zero_pulse) begin
        pulse_mode_reg <= mode_out;
      end
      if (gate_drive_out && !gate_d_reg) gap_reg <= 16'h0001;
      else if (gap_reg != 16'hFFFF) gap_reg <= gap_reg + 16'h0001;
      on_reg <= gate_drive_out ? on_reg + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  pulse_single_a: assert property (
    aux_below_zero_pulse |=> !aux_below_zero_pulse) else $error("long pulse");
  pulse_qualified_a: assert property (
    aux_below_zero_pulse |-> run_reg >= 16'h0014) else $error("short high");
  gate_after_valley_a: assert property (
    $rose(gate_drive_out) |-> $past(aux_below_zero_pulse))
    else $error("gate without valley");
  max_freq_a: assert property (
    $rose(gate_drive_out) |-> gap_reg >= 16'h0595) else $error("too fast");
  startup_ton_a: assert property (
    $fell(gate_drive_out) && pulse_mode_reg == 2'h0 |-> on_reg == 16'h0190)
    else $error("startup on-time");
  startup_entry_a: assert property (
    (output_feedback_current < 16'hE2C2)[*3] |-> mode_out == 2'h0)
    else $error("no startup");
  startup_stay_a: assert property (
    (mode_out == 2'h0 && output_feedback_current < 16'hFBF4)[*2]
    |=> mode_out == 2'h0) else $error("left startup early");
  burst_low_a: assert property (
    (output_power_estimate >= 16'h0CCC)[*3] |-> mode_out != 2'h2)
    else $error("burst at load");
  on_time_cap_a: assert property (
    gate_drive_out |-> on_reg < 16'h0400) else $error("on-time too long");
endmodule
bind pfc_switch_mode_control pfc_ctrl_props chk (
  .core_clk(core_clk),
  .reset(reset),
  .output_feedback_current(output_feedback_current),
  .output_power_estimate(output_power_estimate),
  .demag_sense(demag_sense),
  .gate_drive_out(gate_drive_out),
  .aux_below_zero_pulse(aux_below_zero_pulse),
  .mode_out(mode_out)
);

// file: testbench/pfc_switch_mode_control_bench.sv
// Self-checking bench for the PFC switch-mode controller.
// Assumes the stage model rings the comparator while the gate is off.
`timescale 1ns/1ps
module pfc_switch_mode_control_bench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] fb = 16'hC000;
  logic [15:0] pw = 16'hFFFF;
  logic [15:0] line_code = 16'h2000;
  logic half_line = 1'b0;
  logic [7:0] ring = 8'h1E;
  logic demag, gate, pulse;
  logic [1:0] mode_out;
  int error_cnt = 0;
  int checks_done = 0;
  int hl = 0;
  always #5 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    hl = (hl + 1) % 2000;
    half_line <= (hl == 0);
  end
  pfc_switch_mode_control dut (
    .core_clk(core_clk),
    .reset(reset),
    .output_feedback_current(fb),
    .line_sense_current(line_code),
    .output_power_estimate(pw),
    .half_line_start(half_line),
    .demag_sense(demag),
    .gate_drive_out(gate),
    .aux_below_zero_pulse(pulse),
    .mode_out(mode_out)
  );
  boost_stage_model stage (
    .core_clk(core_clk),
    .gate_drive_out(gate),
    .ring_high(ring),
    .demag_sense(demag)
  );
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, got);
    checks_done++;
    if (exp !== got) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_mode(input logic [1:0] m);
    int i;
    for (i = 0; i < 60 && mode_out !== m; i++) @(negedge core_clk);
    check("mode_out", {14'h0000, m}, {14'h0000, mode_out});
    if (mode_out !== m) end_of_test();
  endtask
  task automatic t_valley;
    int i;
    for (i = 0; i < 600 && pulse !== 1'b1; i++) @(negedge core_clk);
    check("pulse", 16'h0001, {15'h0000, pulse});
    if (pulse !== 1'b1) end_of_test();
    @(negedge core_clk);
    for (i = 0; i < 1000 && gate === 1'b1; i++) @(negedge core_clk);
    check("on_time", 16'h0190, 16'(i));
  endtask
  task automatic t_glitch;
    int i, n;
    ring = 8'h13;
    repeat (1600) @(negedge core_clk);
    n = 0;
    for (i = 0; i < 300; i++) begin
      @(negedge core_clk);
      n += (pulse === 1'b1);
    end
    check("glitch_pulses", 16'h0000, 16'(n));
    ring = 8'h14;
    for (i = 0; i < 600 && pulse !== 1'b1; i++) @(negedge core_clk);
    check("edge_pulse", 16'h0001, {15'h0000, pulse});
    ring = 8'h1E;
  endtask
  task automatic t_offtime;
    int i, n;
    // Off-time 400*0xA000/(0xC000-0xA000) = 2000 outlasts the period floor
    line_code = 16'hA000;
    for (i = 0; i < 3000 && gate !== 1'b1; i++) @(negedge core_clk);
    for (i = 0; i < 1100 && gate === 1'b1; i++) @(negedge core_clk);
    n = 0;
    for (i = 0; i < 3000 && gate !== 1'b1; i++) begin
      @(negedge core_clk);
      n++;
    end
    line_code = 16'h2000;
    checks_done++;
    if (n < 2001 || n > 2045) begin
      error_cnt++;
      $display("wrong value off_time expected 2001 to 2045 seen %0d", n);
    end
  endtask
  task automatic t_burst;
    int i, k, n, idle;
    logic g;
    idle = 0;
    n = 0;
    for (i = 0; i < 2100 && half_line !== 1'b1; i++) @(negedge core_clk);
    g = gate;
    for (k = 0; k < 2; k++) begin
      n = 0;
      for (i = 0; i < 2000; i++) begin
        @(negedge core_clk);
        n += (gate === 1'b1 && g !== 1'b1);
        g = gate;
      end
      idle += (n == 0);
    end
    check("idle_halves", 16'h0001, 16'(idle));
  endtask
  task automatic t_modes;
    fb = 16'hFBF4;
    wait_mode(2'h1);
    fb = 16'hE800;
    repeat (20) @(negedge core_clk);
    check("mode_hold", 16'h0001, {14'h0000, mode_out});
    pw = 16'h0C00;
    wait_mode(2'h2);
    t_burst();
    pw = 16'h1000;
    wait_mode(2'h1);
    fb = 16'hE200;
    wait_mode(2'h0);
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    reset = 1'b0;
    check("mode_reset", 16'h0000, {14'h0000, mode_out});
    t_valley();
    t_offtime();
    t_glitch();
    t_modes();
    end_of_test();
  end
endmodule
